//--- src/crs_pkg.sv
/*
   Package for the chip reset sequencer: timing constants, command codes, state encodings.
   Assumes a single 20 MHz clock shared by both ends.
*/
package crs_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int CLK_MHZ = 20;
   // Times in their own units, as specified
   localparam int RST_MIN_US = 10;
   localparam int DEGLITCH_US = 1;
   localparam int HW_REL_MS = 90;
   localparam int HW_REF_MS = 70;
   localparam int SW_REL_MS = 10;
   localparam int SW_REF_MS = 25;
   localparam int SUB_RST_NS = 1200;
   localparam int OSC_START_US = 100;
   localparam int PLL_LOCK_US = 50;
   localparam int LATCH_CYC = 4;
   // Derived cycle counts: minimums round up, maximums round down
   localparam int RST_MIN_CYC = RST_MIN_US * CLK_MHZ;
   localparam int DEGLITCH_CYC = DEGLITCH_US * CLK_MHZ;
   localparam int HW_REL_CYC = HW_REL_MS * (CLK_HZ / 1000);
   localparam int HW_REF_CYC = HW_REF_MS * (CLK_HZ / 1000);
   localparam int SW_REL_CYC = SW_REL_MS * (CLK_HZ / 1000);
   localparam int SW_REF_CYC = SW_REF_MS * (CLK_HZ / 1000);
   localparam int SUB_RST_CYC = (SUB_RST_NS * CLK_MHZ + 999) / 1000;
   localparam int OSC_CYC = OSC_START_US * CLK_MHZ;
   localparam int PLL_CYC = PLL_LOCK_US * CLK_MHZ;
   // Host command codes on the control strobe
   localparam logic [2:0] CMD_NONE = 3'h0;
   localparam logic [2:0] CMD_SWRST = 3'h1;
   localparam logic [2:0] CMD_SUB1 = 3'h2;
   localparam logic [2:0] CMD_SUB2 = 3'h3;
   localparam logic [2:0] CMD_KEY1 = 3'h4;
   localparam logic [2:0] CMD_KEY2 = 3'h5;
   localparam logic [2:0] CMD_MASK = 3'h6;
   localparam int ERR_W = 4;
   localparam logic [ERR_W-1:0] ERR_NONE = 4'h0;
   typedef enum logic [2:0]
   {
      CRS_OFF = 3'b000,
      CRS_TRI = 3'b001,
      CRS_LATCH = 3'b011,
      CRS_OSC = 3'b010,
      CRS_PLL = 3'b110,
      CRS_WAIT = 3'b111,
      CRS_RUN = 3'b101
   } crs_state_e;
endpackage : crs_pkg

//--- src/crs_if.sv
/*
   Interface joining the host end and the device end of the reset sequencer.
   Assumes both ends share clk; the testbench binds it.
*/
`timescale 1ns/1ps
`default_nettype none
interface crs_if;
   import crs_pkg::*;
   logic reset_n;
   logic [2:0] cmd;
   logic cmd_valid;
   logic [ERR_W-1:0] cmd_data;
   logic [1:0] phy_system_ready;
   logic [1:0] phy_sys_irq;
   logic [ERR_W-1:0] phy_sys_irq_status1;
   logic [ERR_W-1:0] phy_sys_irq_status2;
   logic regs_ready;
   modport device (input reset_n, cmd, cmd_valid, cmd_data,
      output phy_system_ready, phy_sys_irq, phy_sys_irq_status1, phy_sys_irq_status2, regs_ready);
   modport host (output reset_n, cmd, cmd_valid, cmd_data,
      input phy_system_ready, phy_sys_irq, phy_sys_irq_status1, phy_sys_irq_status2, regs_ready);
endinterface : crs_if
`default_nettype wire

//--- src/crs_device.sv
/*
   Device end: power-on, pin, software, PHY subsystem and MAC-only resets,
   reference clock gating, ready status and latched PHY system errors.
   Assumes host drives reset_n and strobes commands synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module crs_device
   import crs_pkg::*;
#(
   parameter int HW_REL = HW_REL_CYC,
   parameter int HW_REF = HW_REF_CYC,
   parameter int SW_REL = SW_REL_CYC,
   parameter int SW_REF = SW_REF_CYC,
   parameter int OSC_T = OSC_CYC,
   parameter int PLL_T = PLL_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Link to host
   crs_if.device lnk,
   // Supplies and straps
   input wire logic power_good,
   input wire logic [3:0] strap_pins,
   input wire logic phy1_soft_pd,
   input wire logic [ERR_W-1:0] phy1_err_evt,
   input wire logic [ERR_W-1:0] phy2_err_evt,
   // Outputs to the chip
   output logic io_functional,
   output logic [3:0] strap_latched,
   output logic osc_enable,
   output logic pll_enable,
   output logic core_rstn,
   output logic phy2_core_rstn,
   output logic [1:0] phy_subsystem_reset,
   output logic mac_rstn,
   output logic tx_abort,
   output logic ref_clock_out
);
   localparam int CW = 32;
   logic [4:0] glitch_cnt;
   logic pin_low;
   logic pin_low_d;
   logic sw_req;
   logic sw_active;
   logic from_sw;
   crs_state_e state;
   logic [CW-1:0] seq_cnt;
   logic [CW-1:0] rel_cnt;
   logic [CW-1:0] ref_cnt;
   logic [1:0] key_seen;
   logic [5:0] sub_cnt1;
   logic [5:0] sub_cnt2;
   logic [5:0] mac_cnt;
   logic [ERR_W-1:0] mask1;
   logic [ERR_W-1:0] mask2;
   logic cmd_ok;

   //----------------------------------------
   // Reset pin filter
   //----------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         glitch_cnt <= 5'h0;
         pin_low <= 1'b1;
      end
      else if (!power_good)
         pin_low <= 1'b1;
      else if (lnk.reset_n)
      begin
         glitch_cnt <= 5'h0;
         pin_low <= 1'b0;
      end
      else if (glitch_cnt >= 5'(DEGLITCH_CYC - 1))
         pin_low <= 1'b1;
      else
         glitch_cnt <= glitch_cnt + 5'h1;
   end

   assign cmd_ok = lnk.cmd_valid && (state == CRS_RUN);
   assign sw_req = cmd_ok && (lnk.cmd == CMD_SWRST);

   //----------------------------------------
   // Start-up sequencer
   //----------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= CRS_OFF;
         seq_cnt <= '0;
         rel_cnt <= '0;
         from_sw <= 1'b0;
         pin_low_d <= 1'b1;
         strap_latched <= 4'h0;
      end
      else
      begin
         pin_low_d <= pin_low;
         if (pin_low)
         begin
            state <= CRS_OFF;
            from_sw <= 1'b0;
            rel_cnt <= '0;
         end
         else
         begin
            if (state != CRS_RUN)
               rel_cnt <= rel_cnt + 1'b1;
            unique case (state)
               CRS_OFF:
                  state <= CRS_TRI;
               CRS_TRI:
               begin
                  state <= CRS_LATCH;
                  seq_cnt <= '0;
               end
               CRS_LATCH:
               begin
                  strap_latched <= strap_pins;
                  seq_cnt <= seq_cnt + 1'b1;
                  if (seq_cnt >= CW'(LATCH_CYC - 1))
                  begin
                     state <= CRS_OSC;
                     seq_cnt <= '0;
                  end
               end
               CRS_OSC:
               begin
                  seq_cnt <= seq_cnt + 1'b1;
                  if (seq_cnt >= CW'(OSC_T - 1))
                  begin
                     state <= CRS_PLL;
                     seq_cnt <= '0;
                  end
               end
               CRS_PLL:
               begin
                  seq_cnt <= seq_cnt + 1'b1;
                  if (seq_cnt >= CW'(PLL_T - 1))
                     state <= CRS_WAIT;
               end
               CRS_WAIT:
                  // Release counted from pin/write, including the cycles before the PLL is enabled
                  if (rel_cnt >= CW'((from_sw ? SW_REL : HW_REL) - 1))
                     state <= CRS_RUN;
               CRS_RUN:
                  if (sw_req)
                  begin
                     state <= CRS_TRI;
                     from_sw <= 1'b1;
                     rel_cnt <= '0;
                  end
            endcase
         end
      end
   end

   //----------------------------------------
   // Outputs of the sequencer
   //----------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         io_functional <= 1'b0;
         osc_enable <= 1'b0;
         pll_enable <= 1'b0;
         core_rstn <= 1'b0;
         phy2_core_rstn <= 1'b0;
         tx_abort <= 1'b0;
         lnk.regs_ready <= 1'b0;
      end
      else
      begin
         io_functional <= (state != CRS_OFF) && (state != CRS_TRI) && (state != CRS_LATCH);
         osc_enable <= (state == CRS_OSC) || (state == CRS_PLL) || (state == CRS_WAIT) || (state == CRS_RUN);
         pll_enable <= (state == CRS_PLL) || (state == CRS_WAIT) || (state == CRS_RUN);
         core_rstn <= (state == CRS_RUN) && !sw_req;
         lnk.regs_ready <= (state == CRS_RUN) && !sw_req;
         // Soft reset leaves the second port's core reset alone
         phy2_core_rstn <= pin_low ? 1'b0 : (phy2_core_rstn || (state == CRS_RUN));
         tx_abort <= sw_req;
      end
   end

   //----------------------------------------
   // Reference clock hold-off
   //----------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ref_cnt <= '0;
         ref_clock_out <= 1'b0;
      end
      else if (pin_low || sw_req)
      begin
         ref_cnt <= '0;
         ref_clock_out <= 1'b0;
      end
      else if (ref_cnt < CW'((from_sw ? SW_REF : HW_REF) - 1))
      begin
         ref_cnt <= ref_cnt + 1'b1;
         ref_clock_out <= 1'b0;
      end
      else
         ref_clock_out <= ~ref_clock_out;
   end

   //----------------------------------------
   // PHY subsystem and MAC-only resets
   //----------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sub_cnt1 <= 6'h0;
         sub_cnt2 <= 6'h0;
         mac_cnt <= 6'h0;
         key_seen <= 2'h0;
         phy_subsystem_reset <= 2'h0;
         mac_rstn <= 1'b0;
      end
      else
      begin
         // Management registers sit outside these resets and stay reachable
         if (cmd_ok && lnk.cmd == CMD_SUB1)
            sub_cnt1 <= 6'(SUB_RST_CYC);
         else if (sub_cnt1 != 6'h0)
            sub_cnt1 <= sub_cnt1 - 6'h1;
         if (cmd_ok && lnk.cmd == CMD_SUB2)
            sub_cnt2 <= 6'(SUB_RST_CYC);
         else if (sub_cnt2 != 6'h0)
            sub_cnt2 <= sub_cnt2 - 6'h1;
         phy_subsystem_reset <= {sub_cnt2 > 6'h1, sub_cnt1 > 6'h1} |
            {cmd_ok && lnk.cmd == CMD_SUB2, cmd_ok && lnk.cmd == CMD_SUB1};
         // Key pair: any other command breaks the sequence
         if (cmd_ok)
            key_seen <= (lnk.cmd == CMD_KEY1) ? 2'h1 : 2'h0;
         if (cmd_ok && lnk.cmd == CMD_KEY2 && key_seen == 2'h1 && !phy1_soft_pd)
            mac_cnt <= 6'(SUB_RST_CYC);
         else if (mac_cnt != 6'h0)
            mac_cnt <= mac_cnt - 6'h1;
         // Only the MAC datapath is reset; links and PHY state are untouched
         mac_rstn <= (state == CRS_RUN) && (mac_cnt <= 6'h1) &&
            !(cmd_ok && lnk.cmd == CMD_KEY2 && key_seen == 2'h1 && !phy1_soft_pd);
      end
   end

   //----------------------------------------
   // Ready and latched system errors
   //----------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mask1 <= ERR_NONE;
         mask2 <= ERR_NONE;
         lnk.phy_sys_irq_status1 <= ERR_NONE;
         lnk.phy_sys_irq_status2 <= ERR_NONE;
         lnk.phy_sys_irq <= 2'h0;
         lnk.phy_system_ready <= 2'h0;
      end
      else if (pin_low)
      begin
         // Only a hardware reset clears the error latches
         mask1 <= ERR_NONE;
         mask2 <= ERR_NONE;
         lnk.phy_sys_irq_status1 <= ERR_NONE;
         lnk.phy_sys_irq_status2 <= ERR_NONE;
         lnk.phy_sys_irq <= 2'h0;
         lnk.phy_system_ready <= 2'h0;
      end
      else
      begin
         if (cmd_ok && lnk.cmd == CMD_MASK)
         begin
            mask1 <= lnk.cmd_data;
            mask2 <= lnk.cmd_data;
         end
         lnk.phy_sys_irq_status1 <= lnk.phy_sys_irq_status1 | phy1_err_evt;
         lnk.phy_sys_irq_status2 <= lnk.phy_sys_irq_status2 | phy2_err_evt;
         lnk.phy_sys_irq <= {|(lnk.phy_sys_irq_status2 & mask2), |(lnk.phy_sys_irq_status1 & mask1)};
         lnk.phy_system_ready <= {phy2_core_rstn && (state == CRS_RUN), (state == CRS_RUN) && !sw_req};
      end
   end
endmodule : crs_device
`default_nettype wire

//--- src/crs_host.sv
/*
   Host end: drives the reset pin for the minimum time and issues commands.
   Assumes user strobes are single-cycle and synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module crs_host
   import crs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Link to device
   crs_if.host lnk,
   // User side
   input wire logic hw_reset_req,
   input wire logic cmd_req,
   input wire logic [2:0] cmd_code,
   input wire logic [ERR_W-1:0] cmd_arg,
   output logic busy,
   output logic recover_needed
);
   logic [8:0] low_cnt;

   //----------------------------------------
   // Reset pin pulse
   //----------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         low_cnt <= 9'h0;
         lnk.reset_n <= 1'b1;
         busy <= 1'b0;
      end
      else if (hw_reset_req && !busy)
      begin
         low_cnt <= 9'(RST_MIN_CYC);
         lnk.reset_n <= 1'b0;
         busy <= 1'b1;
      end
      else if (low_cnt > 9'h1)
         low_cnt <= low_cnt - 9'h1;
      else
      begin
         low_cnt <= 9'h0;
         lnk.reset_n <= 1'b1;
         busy <= 1'b0;
      end
   end

   //----------------------------------------
   // Command strobe and error watch
   //----------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         lnk.cmd <= CMD_NONE;
         lnk.cmd_valid <= 1'b0;
         lnk.cmd_data <= ERR_NONE;
         recover_needed <= 1'b0;
      end
      else
      begin
         lnk.cmd_valid <= cmd_req && lnk.regs_ready;
         lnk.cmd <= cmd_req ? cmd_code : CMD_NONE;
         lnk.cmd_data <= cmd_arg;
         // A latched error is only cured by pulsing the pin
         recover_needed <= (|lnk.phy_sys_irq_status1) || (|lnk.phy_sys_irq_status2) || (|lnk.phy_sys_irq);
      end
   end
endmodule : crs_host
`default_nettype wire

//--- bench/crs_chk.sv
/*
   Checker on the host-device link of the reset sequencer.
   Assumes the device clock and reset are passed in beside the link signals.
*/
`timescale 1ns/1ps
`default_nettype none
module crs_chk
   import crs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Link
   input wire logic reset_n,
   input wire logic [2:0] cmd,
   input wire logic cmd_valid,
   input wire logic [ERR_W-1:0] cmd_data,
   input wire logic [1:0] phy_system_ready,
   input wire logic [1:0] phy_sys_irq,
   input wire logic [ERR_W-1:0] phy_sys_irq_status1,
   input wire logic [ERR_W-1:0] phy_sys_irq_status2,
   input wire logic regs_ready
);
   logic [7:0] low_cnt;
   logic [ERR_W-1:0] mask_q;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // ------------------------------
   // Helper state
   // ------------------------------
   // Saturates so a long hold never wraps back into the glitch range
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         low_cnt <= 8'h00;
      else if (reset_n)
         low_cnt <= 8'h00;
      else if (low_cnt != 8'hFF)
         low_cnt <= low_cnt + 8'h01;
   end
   // Never cleared by the pin, so it can only be looser than the device
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         mask_q <= '0;
      else if (regs_ready && cmd_valid && cmd == CMD_MASK)
         mask_q <= cmd_data;
   end
   // ------------------------------
   // Properties
   // ------------------------------
   sequence sw_take;
      regs_ready && cmd_valid && cmd == CMD_SWRST;
   endsequence
   sequence sw_back;
      !regs_ready ##[1:302] regs_ready;
   endsequence
   chk_sw_restart: assert property (sw_take |=> sw_back)
      else $error("soft reset did not drop and restore ready");
   chk_hw_release: assert property ($rose(reset_n) |-> ##[1:405] regs_ready)
      else $error("ready late after pin release");
   chk_pin_width: assert property ($rose(reset_n) |-> low_cnt >= 8'hC7)
      else $error("reset pin pulse too short");
   chk_pin_resets: assert property (low_cnt >= 8'h18 |-> !regs_ready)
      else $error("long pin low did not reset");
   chk_glitch_kept: assert property (regs_ready && !reset_n && low_cnt < 8'h10 && !cmd_valid |=> regs_ready)
      else $error("short pin low dropped ready");
   chk_err_sticky: assert property (reset_n[*3] |->
      ({phy_sys_irq_status1, phy_sys_irq_status2} & $past({phy_sys_irq_status1, phy_sys_irq_status2}))
      == $past({phy_sys_irq_status1, phy_sys_irq_status2}))
      else $error("error status cleared without pin reset");
   chk_err_cleared: assert property (low_cnt == 8'h20 |-> {phy_sys_irq_status1, phy_sys_irq_status2} == '0)
      else $error("error status kept through pin reset");
   chk_irq_masked: assert property (phy_sys_irq != 2'b00 |->
      phy_sys_irq <= {|(phy_sys_irq_status2 & $past(mask_q, 2)), |(phy_sys_irq_status1 & $past(mask_q, 2))})
      else $error("error signalled while masked off");
   chk_cmd_gated: assert property (cmd_valid |-> $past(regs_ready))
      else $error("command sent while not ready");
   chk_sys_ready: assert property ($rose(regs_ready) |-> ##[0:2] phy_system_ready[0])
      else $error("system ready missing after start-up");
endmodule : crs_chk
`default_nettype wire

//--- bench/crs_bench.sv
/*
   Bench for the reset sequencer: host end faces device end on one link,
   a second device is driven straight from the bench for misuse cases.
   Assumes the shortened timing parameters given at the instances.
*/
`timescale 1ns/1ps
`default_nettype none
module crs_bench
   import crs_pkg::*;
;
   typedef struct packed
   {
      logic [2:0] code;
      logic [3:0] arg;
      logic [1:0] sub;
      logic mac;
   } crs_row_s;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic power_good = 1'b0;
   logic [3:0] strap_pins = 4'hA;
   logic soft_pd = 1'b0;
   logic [3:0] e1 = 4'h0;
   logic [3:0] e2 = 4'h0;
   logic hw_req = 1'b0;
   logic cmd_req = 1'b0;
   logic [2:0] code = CMD_NONE;
   logic [3:0] arg = 4'h0;
   logic busy, io_f, osc, pll, core, phy2, mac, mac2, txa, refc;
   logic [3:0] strap_q;
   logic [1:0] sub;
   logic io2, osc2, pll2, core2, phy22, txa2, refc2, recov;
   logic [3:0] strap2;
   logic [1:0] sub2;
   int fails = 0;
   int num_checks = 0;
   int tx_cnt = 0;
   int n;
   crs_row_s rows [5];
   crs_if l1 ();
   crs_if l2 ();
   always #25 clk = ~clk;
   // ------------------------------
   // Design and checker
   // ------------------------------
   crs_host crs_host_i (.clk(clk), .rstn(rstn), .lnk(l1), .hw_reset_req(hw_req), .cmd_req(cmd_req),
      .cmd_code(code), .cmd_arg(arg), .busy(busy), .recover_needed(recov));
   crs_device #(.HW_REL(400), .HW_REF(500), .SW_REL(300), .SW_REF(350), .OSC_T(20), .PLL_T(20)) crs_device_i (
      .clk(clk), .rstn(rstn), .lnk(l1), .power_good(power_good), .strap_pins(strap_pins),
      .phy1_soft_pd(soft_pd), .phy1_err_evt(e1), .phy2_err_evt(e2), .io_functional(io_f),
      .strap_latched(strap_q), .osc_enable(osc), .pll_enable(pll), .core_rstn(core), .phy2_core_rstn(phy2),
      .phy_subsystem_reset(sub), .mac_rstn(mac), .tx_abort(txa), .ref_clock_out(refc));
   crs_device #(.HW_REL(400), .HW_REF(500), .SW_REL(300), .SW_REF(350), .OSC_T(20), .PLL_T(20)) crs_device_i2 (
      .clk(clk), .rstn(rstn), .lnk(l2), .power_good(power_good), .strap_pins(strap_pins),
      .phy1_soft_pd(soft_pd), .phy1_err_evt(e1), .phy2_err_evt(e2), .io_functional(io2),
      .strap_latched(strap2), .osc_enable(osc2), .pll_enable(pll2), .core_rstn(core2), .phy2_core_rstn(phy22),
      .phy_subsystem_reset(sub2), .mac_rstn(mac2), .tx_abort(txa2), .ref_clock_out(refc2));
   crs_chk crs_chk_i (.clk(clk), .rstn(rstn), .reset_n(l1.reset_n), .cmd(l1.cmd), .cmd_valid(l1.cmd_valid),
      .cmd_data(l1.cmd_data), .phy_system_ready(l1.phy_system_ready), .phy_sys_irq(l1.phy_sys_irq),
      .phy_sys_irq_status1(l1.phy_sys_irq_status1), .phy_sys_irq_status2(l1.phy_sys_irq_status2),
      .regs_ready(l1.regs_ready));
   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc
   task automatic host_cmd(input logic [2:0] c, input logic [3:0] a);
      code = c;
      arg = a;
      cmd_req = 1'b1;
      cyc(1);
      cmd_req = 1'b0;
      n = 0;
      while (l1.cmd_valid !== 1'b1 && n < 8)
      begin
         cyc(1);
         n++;
      end
      cmp(n < 8, 1'b1);
   endtask : host_cmd
   task automatic wait_rdy(input int lim);
      n = 0;
      while (!(l1.regs_ready === 1'b1 && l2.regs_ready === 1'b1) && n < lim)
      begin
         cyc(1);
         n++;
      end
      cmp(n < lim, 1'b1);
   endtask : wait_rdy
   // Counts from the call, so callers start it at the reset they measure
   task automatic ref_gap(input int lim);
      n = 0;
      while (refc !== 1'b1 && n < lim)
      begin
         cyc(1);
         n++;
      end
      cmp(n < lim, 1'b1);
   endtask : ref_gap
   task automatic wrap_up;
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   always @(posedge clk)
      if (txa === 1'b1)
         tx_cnt++;
   always @(negedge clk)
      if (pll === 1'b1)
         cmp(osc, 1'b1);
   initial
   begin
      #(20000 * 50);
      fails++;
      wrap_up();
   end
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial
   begin
      l2.reset_n = 1'b1;
      l2.cmd = CMD_NONE;
      l2.cmd_valid = 1'b0;
      l2.cmd_data = 4'h0;
      rows[0] = {CMD_SUB1, 4'h0, 2'b01, 1'b0};
      rows[1] = {CMD_SUB2, 4'h0, 2'b10, 1'b0};
      rows[2] = {CMD_KEY1, 4'h0, 2'b00, 1'b0};
      rows[3] = {CMD_KEY2, 4'h0, 2'b00, 1'b1};
      rows[4] = {CMD_MASK, 4'h3, 2'b00, 1'b0};
      cyc(16);
      rstn = 1'b1;
      cyc(40);
      cmp(l1.regs_ready, 1'b0);
      power_good = 1'b1;
      wait_rdy(600);
      cmp({osc, pll, core, phy2, io_f, strap_q}, 9'h1FA);
      cmp({osc2, pll2, core2, phy22, io2, strap2}, 9'h1FA);
      strap_pins = 4'h5;
      for (int i = 0; i < 5; i++)
      begin
         host_cmd(rows[i].code, rows[i].arg);
         cyc(2);
         cmp({sub, ~mac, l1.regs_ready}, {rows[i].sub, rows[i].mac, 1'b1});
         cyc(30);
         cmp({sub, mac}, 3'b001);
      end
      e1 = 4'h1;
      e2 = 4'h4;
      cyc(1);
      e1 = 4'h0;
      e2 = 4'h0;
      cyc(4);
      cmp({l1.phy_sys_irq_status1, l1.phy_sys_irq_status2}, 8'h14);
      cmp({l1.phy_sys_irq, l2.phy_sys_irq}, 4'h4);
      cmp(recov, 1'b1);
      soft_pd = 1'b1;
      host_cmd(CMD_KEY1, 4'h0);
      host_cmd(CMD_KEY2, 4'h0);
      cyc(2);
      cmp(mac, 1'b1);
      soft_pd = 1'b0;
      host_cmd(CMD_SWRST, 4'h0);
      cyc(1);
      cmp({l1.regs_ready, phy2, refc}, 3'b010);
      ref_gap(352);
      cmp(tx_cnt, 1);
      cmp({l1.phy_sys_irq_status1, l1.phy_sys_irq_status2, strap_q}, 12'h145);
      hw_req = 1'b1;
      cyc(1);
      hw_req = 1'b0;
      cyc(100);
      cmp({busy, refc, core, io_f, l1.regs_ready}, 5'h10);
      n = 0;
      while (busy === 1'b1 && n < 300)
      begin
         cyc(1);
         n++;
      end
      ref_gap(505);
      cmp({l1.phy_sys_irq_status1, l1.phy_sys_irq_status2, l1.phy_sys_irq, recov}, 11'h000);
      l2.reset_n = 1'b0;
      cyc(15);
      l2.reset_n = 1'b1;
      cyc(3);
      cmp({l2.regs_ready, core2}, 2'b11);
      l2.cmd = CMD_KEY2;
      l2.cmd_valid = 1'b1;
      cyc(1);
      l2.cmd_valid = 1'b0;
      cyc(2);
      cmp(mac2, 1'b1);
      l2.reset_n = 1'b0;
      cyc(200);
      l2.reset_n = 1'b1;
      cmp({l2.regs_ready, core2, io2}, 3'b000);
      wait_rdy(600);
      cmp({sub2, txa2, refc2}, 4'h0);
      wrap_up();
   end
endmodule : crs_bench
`default_nettype wire
